// ---- logic/cnls_regs.vh ----
`ifndef CNLS_REGS_VH
`define CNLS_REGS_VH

// register map (byte addresses)
`define CNLS_ADDR_CTRL 8'h00
`define CNLS_ADDR_ACT 8'h04
`define CNLS_ADDR_FRAME 8'h08
`define CNLS_ADDR_RESULT 8'h0C
`define CNLS_ADDR_STATUS 8'h10

// action word field positions
`define CNLS_ACT_KEY_LSB 0
`define CNLS_ACT_WORD_LSB 4
`define CNLS_ACT_HALF_LSB 6
`define CNLS_ACT_LSKIP_LSB 11
`define CNLS_ACT_AFTER_LSB 13
`define CNLS_ACT_STRIP_BIT 15
`define CNLS_ACT_FMT_LSB 16
`define CNLS_ACT_GO_BIT 31

// frame descriptor field positions
`define CNLS_FRM_PTR_LSB 0
`define CNLS_FRM_TYPE_LSB 8
`define CNLS_FRM_VLAN_LSB 10
`define CNLS_FRM_IPV_LSB 12
`define CNLS_FRM_IHL_LSB 16

// action formats
`define CNLS_FMT_LABEL 2'h0
`define CNLS_FMT_REDUCED 2'h1
`define CNLS_FMT_CLASS 2'h2
`define CNLS_FMT_FULL 2'h3

// frame layer types
`define CNLS_LT_ETH 2'h0
`define CNLS_LT_CW 2'h1
`define CNLS_LT_MPLS 2'h2
`define CNLS_LT_DATA 2'h3

// layer skip modes
`define CNLS_LS_NONE 2'h0
`define CNLS_LS_LINK 2'h1
`define CNLS_LS_NET 2'h2

// key types driven to the next lookup
`define CNLS_KT_DEFAULT 5'h00
`define CNLS_KT_MPLS_LEVEL 5'h01
`define CNLS_KT_ONE_LABEL 5'h02
`define CNLS_KT_TWO_LABEL 5'h03
`define CNLS_KT_THREE_LABEL 5'h04
`define CNLS_KT_TRIPLE_VLAN 5'h05
`define CNLS_KT_TRIPLE_VLAN_IDX 5'h06
`define CNLS_KT_FULL_LINK 5'h07
`define CNLS_KT_NORMAL 5'h08
`define CNLS_KT_NORMAL_DST 5'h09
`define CNLS_KT_SEVEN_TUPLE 5'h0A
`define CNLS_KT_NORM_IPV4_5T 5'h0B
`define CNLS_KT_PURE_IPV4_5T 5'h0C
`define CNLS_KT_FIRST_CUSTOM_KEY 5'h0D
`define CNLS_KT_SECOND_CUSTOM_KEY 5'h0E
`define CNLS_KT_FOURTH_CUSTOM_KEY 5'h0F
`define CNLS_KT_DONE 5'h1F

// layer sizes in bytes
`define CNLS_MAC_PAIR_BYTES 8'h0C
`define CNLS_VLAN_BYTES 8'h04
`define CNLS_ETYPE_BYTES 8'h02
`define CNLS_IPV6_HDR_BYTES 8'h28
`define CNLS_MAX_STRIP 8'h2A

`endif

// ---- logic/cnls_steer.v ----
// Functional notes
// - 4-bit next key select; zero keeps default
// - codes 1-4 pick label-stack key types
// - code 5 picks triple-VLAN variant by config
// - code 8 normal key with destination fields
// - codes 6,7,9-14 pick remaining key types
// - code 15 disables all remaining lookups
// - word skip moves pointer by 4-byte units
// - halfword skip moves pointer by 2-byte units
// - auto-skipped labels not counted in offsets
// - layer skip first, then fixed offset
// - layer skip 0 none, 1 past Ethernet
// - layer skip 2 past Ethernet and IP
// - IPv4 skip follows real header length
// - layer-after-move sets type at new pointer
// - type changes only on move or raw+key
// - strip flag removes data before pointer
// - pointer updated before strip is applied
// - strip never more than 42 bytes
`timescale 1ns/10ps
`include "cnls_regs.vh"

module cnls_steer (
    input wire sys_clk_i,
    input wire rst_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hsel_i,
    input wire hready_i,
    output wire hreadyout_o,
    output wire hresp_o,
    output reg [31:0] hrdata_o,
    output reg [4:0] next_key_o,
    output reg lookups_finished_o,
    output reg dst_in_source_mac_key_field_o,
    output reg dst_in_ipv4_source_key_field_o,
    output reg [7:0] frame_ptr_o,
    output reg [1:0] frame_type_o,
    output reg strip_to_pointer_o,
    output reg [7:0] strip_bytes_o,
    output reg result_valid_o
);

    reg ctrl_variant_q;
    reg [31:0] act_q;
    reg [31:0] frame_q;
    reg [7:0] err_cnt_q;
    reg clamp_seen_q;
    reg wr_pend_q;
    reg [7:0] wr_addr_q;
    reg go_d;
    reg [4:0] key_d;
    reg [7:0] ptr_d;
    reg [7:0] layer_len;
    reg [1:0] type_d;
    reg strip_d;
    reg [7:0] strip_len_d;
    reg clamp_d;

    wire addr_phase = hsel_i && hready_i && htrans_i[1];
    wire [3:0] next_key_select = act_q[`CNLS_ACT_KEY_LSB +: 4];
    wire [1:0] word_skip_count = act_q[`CNLS_ACT_WORD_LSB +: 2];
    wire [4:0] halfword_skip_count = act_q[`CNLS_ACT_HALF_LSB +: 5];
    wire [1:0] layer_skip_mode = act_q[`CNLS_ACT_LSKIP_LSB +: 2];
    wire [1:0] layer_after_move = act_q[`CNLS_ACT_AFTER_LSB +: 2];
    wire strip_to_pointer = act_q[`CNLS_ACT_STRIP_BIT];
    wire [1:0] act_fmt = act_q[`CNLS_ACT_FMT_LSB +: 2];
    wire [7:0] in_ptr = frame_q[`CNLS_FRM_PTR_LSB +: 8];
    wire [1:0] in_type = frame_q[`CNLS_FRM_TYPE_LSB +: 2];
    wire [1:0] vlan_cnt = frame_q[`CNLS_FRM_VLAN_LSB +: 2];
    wire [3:0] ip_ver = frame_q[`CNLS_FRM_IPV_LSB +: 4];
    wire [3:0] ipv4_ihl = frame_q[`CNLS_FRM_IHL_LSB +: 4];

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // bytes of the Ethernet part: both MACs, tags, ethertype
    function [7:0] eth_len;
        input [1:0] tags;
        begin
            eth_len = `CNLS_MAC_PAIR_BYTES + {tags, 2'b00} + `CNLS_ETYPE_BYTES;
        end
    endfunction

    // bytes of the IP header; IPv4 length comes from the header itself
    function [7:0] ip_len;
        input [3:0] ver;
        input [3:0] ihl;
        begin
            if (ver == 4'h4) begin
                ip_len = {2'b00, ihl, 2'b00};
            end else if (ver == 4'h6) begin
                ip_len = `CNLS_IPV6_HDR_BYTES;
            end else begin
                ip_len = 8'h00;
            end
        end
    endfunction

    always @* begin
        key_d = `CNLS_KT_DEFAULT;
        case (next_key_select)
            4'h0: key_d = `CNLS_KT_DEFAULT;
            4'h1: key_d = `CNLS_KT_MPLS_LEVEL;
            4'h2: key_d = `CNLS_KT_ONE_LABEL;
            4'h3: key_d = `CNLS_KT_TWO_LABEL;
            4'h4: key_d = `CNLS_KT_THREE_LABEL;
            4'h5: key_d = ctrl_variant_q ? `CNLS_KT_TRIPLE_VLAN_IDX : `CNLS_KT_TRIPLE_VLAN;
            4'h6: key_d = `CNLS_KT_FULL_LINK;
            4'h7: key_d = `CNLS_KT_NORMAL;
            4'h8: key_d = `CNLS_KT_NORMAL_DST;
            4'h9: key_d = `CNLS_KT_SEVEN_TUPLE;
            4'hA: key_d = `CNLS_KT_NORM_IPV4_5T;
            4'hB: key_d = `CNLS_KT_PURE_IPV4_5T;
            4'hC: key_d = `CNLS_KT_FIRST_CUSTOM_KEY;
            4'hD: key_d = `CNLS_KT_SECOND_CUSTOM_KEY;
            4'hE: key_d = `CNLS_KT_FOURTH_CUSTOM_KEY;
            4'hF: key_d = `CNLS_KT_DONE;
            default: key_d = `CNLS_KT_DEFAULT;
        endcase
    end

    // the incoming pointer already sits past auto-skipped labels, so offsets add to it as is
    always @* begin
        layer_len = 8'h00;
        case (layer_skip_mode)
            `CNLS_LS_LINK: begin
                if (in_type == `CNLS_LT_ETH) begin
                    layer_len = eth_len(vlan_cnt);
                end
            end
            `CNLS_LS_NET: begin
                if (in_type == `CNLS_LT_ETH) begin
                    layer_len = eth_len(vlan_cnt) + ip_len(ip_ver, ipv4_ihl);
                end else if (in_type == `CNLS_LT_CW) begin
                    layer_len = ip_len(ip_ver, ipv4_ihl);
                end
            end
            default: layer_len = 8'h00;
        endcase
        ptr_d = in_ptr + layer_len;
        if (act_fmt == `CNLS_FMT_REDUCED) begin
            ptr_d = ptr_d + {4'h0, word_skip_count, 2'b00};
        end else begin
            ptr_d = ptr_d + {2'b00, halfword_skip_count, 1'b0};
        end
    end

    always @* begin
        type_d = in_type;
        if ((ptr_d != in_ptr) || ((in_type == `CNLS_LT_DATA) && (next_key_select != 4'h0))) begin
            type_d = layer_after_move;
        end
        strip_d = strip_to_pointer;
        clamp_d = 1'b0;
        strip_len_d = 8'h00;
        if (strip_to_pointer) begin
            // strip length taken from the updated pointer, never the incoming one
            if (ptr_d > `CNLS_MAX_STRIP) begin
                strip_len_d = `CNLS_MAX_STRIP;
                clamp_d = 1'b1;
            end else begin
                strip_len_d = ptr_d;
            end
        end
    end

    // writes land one cycle after the address phase, as the data phase dictates
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_phase && hwrite_i;
            wr_addr_q <= haddr_i[7:0];
        end
    end

    always @* begin
        go_d = wr_pend_q && (wr_addr_q == `CNLS_ADDR_ACT) && hwdata_i[`CNLS_ACT_GO_BIT];
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl_variant_q <= 1'b0;
            act_q <= 32'h00000000;
            frame_q <= 32'h00000000;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                `CNLS_ADDR_CTRL: ctrl_variant_q <= hwdata_i[0];
                `CNLS_ADDR_ACT: act_q <= {1'b0, hwdata_i[30:0]};
                `CNLS_ADDR_FRAME: frame_q <= hwdata_i;
                default: ctrl_variant_q <= ctrl_variant_q;
            endcase
        end
    end

    // one apply stage: results launch the cycle after the action is armed
    reg apply_q;
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            apply_q <= 1'b0;
            next_key_o <= `CNLS_KT_DEFAULT;
            lookups_finished_o <= 1'b0;
            dst_in_source_mac_key_field_o <= 1'b0;
            dst_in_ipv4_source_key_field_o <= 1'b0;
            frame_ptr_o <= 8'h00;
            frame_type_o <= `CNLS_LT_ETH;
            strip_to_pointer_o <= 1'b0;
            strip_bytes_o <= 8'h00;
            result_valid_o <= 1'b0;
            err_cnt_q <= 8'h00;
            clamp_seen_q <= 1'b0;
        end else begin
            apply_q <= go_d;
            result_valid_o <= apply_q;
            if (apply_q) begin
                next_key_o <= key_d;
                lookups_finished_o <= (key_d == `CNLS_KT_DONE);
                dst_in_source_mac_key_field_o <= (key_d == `CNLS_KT_NORMAL_DST);
                dst_in_ipv4_source_key_field_o <= (key_d == `CNLS_KT_NORMAL_DST);
                frame_ptr_o <= ptr_d;
                frame_type_o <= type_d;
                strip_to_pointer_o <= strip_d;
                strip_bytes_o <= strip_len_d;
                if (clamp_d) begin
                    clamp_seen_q <= 1'b1;
                    err_cnt_q <= err_cnt_q + 8'h01;
                end
            end
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            hrdata_o <= 32'h00000000;
        end else if (addr_phase && !hwrite_i) begin
            case (haddr_i[7:0])
                `CNLS_ADDR_CTRL: hrdata_o <= {31'h00000000, ctrl_variant_q};
                `CNLS_ADDR_ACT: hrdata_o <= act_q;
                `CNLS_ADDR_FRAME: hrdata_o <= frame_q;
                `CNLS_ADDR_RESULT: hrdata_o <= {6'h00, strip_bytes_o, frame_ptr_o, strip_to_pointer_o,
                    lookups_finished_o, frame_type_o, 1'b0, next_key_o};
                `CNLS_ADDR_STATUS: hrdata_o <= {22'h000000, clamp_seen_q, apply_q, err_cnt_q};
                default: hrdata_o <= 32'h00000000;
            endcase
        end
    end

endmodule // cnls_steer

// ---- dv/cnls_steer_sva.sv ----
`timescale 1ns/10ps
module cnls_steer_sva (
    input wire sys_clk_i,
    input wire rst_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [31:0] hwdata_i,
    input wire hsel_i,
    input wire hreadyout_o,
    input wire hresp_o,
    input wire [4:0] next_key_o,
    input wire lookups_finished_o,
    input wire dst_in_source_mac_key_field_o,
    input wire [7:0] frame_ptr_o,
    input wire strip_to_pointer_o,
    input wire [7:0] strip_bytes_o,
    input wire result_valid_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence act_addr;
        hsel_i && htrans_i[1] && hwrite_i && haddr_i[7:0] == 8'h04;
    endsequence
    sequence go_write;
        act_addr ##1 hwdata_i[31];
    endsequence
    a_bus_no_wait: assert property (hsel_i && htrans_i[1] |=> hreadyout_o && !hresp_o) else $error("bus stalled");
    a_go_gives_result: assert property (go_write |-> ##[1:4] result_valid_o) else $error("no result");
    a_result_one_cycle: assert property (result_valid_o |=> !result_valid_o) else $error("long pulse");
    a_done_tracks_key: assert property (lookups_finished_o == (next_key_o == 5'h1F)) else $error("done");
    a_dst_key_field: assert property (dst_in_source_mac_key_field_o == (next_key_o == 5'h09)) else $error("dst");
    a_strip_ceiling: assert property (strip_bytes_o <= 8'h2A) else $error("strip over");
    a_no_strip_zero: assert property (!strip_to_pointer_o |-> strip_bytes_o == 8'h00) else $error("strip");
    a_strip_at_ptr: assert property (result_valid_o && strip_to_pointer_o |->
        strip_bytes_o == ((frame_ptr_o > 8'h2A) ? 8'h2A : frame_ptr_o)) else $error("strip count");
endmodule // cnls_steer_sva

// ---- dv/cnls_far_model.sv ----
`timescale 1ns/10ps
module cnls_far_model (
    input wire sys_clk_i,
    input wire rst_i,
    input wire result_valid_i,
    input wire strip_i,
    input wire [7:0] strip_bytes_i,
    output reg [7:0] taken_bytes_o,
    output reg [7:0] applies_o
);
    // rewriter takes the count only with a result pulse that carries the strip flag, and holds it between frames
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            taken_bytes_o <= 8'h00;
            applies_o <= 8'h00;
        end else if (result_valid_i) begin
            applies_o <= applies_o + 8'h01;
            if (strip_i) begin
                taken_bytes_o <= strip_bytes_i;
            end
        end
    end
endmodule // cnls_far_model

// ---- dv/cnls_steer_tb.sv ----
`timescale 1ns/10ps
module cnls_steer_tb;
    logic sys_clk_i;
    logic rst_i;
    logic hwrite;
    logic hsel;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] rd;
    wire hready, hresp, done, dmac, dip, strip, rv;
    wire [31:0] hrdata;
    wire [4:0] key;
    wire [7:0] ptr, sbytes, taken, applies;
    wire [1:0] ftype;
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_apply = 0;

    cnls_steer u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hsel_i(hsel), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
        .hrdata_o(hrdata), .next_key_o(key), .lookups_finished_o(done), .dst_in_source_mac_key_field_o(dmac),
        .dst_in_ipv4_source_key_field_o(dip), .frame_ptr_o(ptr), .frame_type_o(ftype), .strip_to_pointer_o(strip),
        .strip_bytes_o(sbytes), .result_valid_o(rv));
    cnls_far_model u_far (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .result_valid_i(rv), .strip_i(strip),
        .strip_bytes_i(sbytes), .taken_bytes_o(taken), .applies_o(applies));

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            results();
        end
    end

    task results;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge sys_clk_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // frame descriptor must land before the action that uses it
    task apply(input logic [31:0] f, input logic [31:0] a);
        bus(1'b1, 32'h08, f);
        bus(1'b1, 32'h04, a);
        n_apply++;
        // look between edges so the one-cycle pulse is seen while it stands, not at its launch
        for (int i = 0; i < 8 && rv !== 1'b1; i++) @(negedge sys_clk_i);
        cmp("result_valid", 32'h1, rv);
    endtask
    task pt(input logic [31:0] f, input logic [31:0] a, input logic [7:0] p, input logic [1:0] t, input logic [7:0] s);
        apply(f, a);
        cmp("frame_ptr", p, ptr);
        cmp("frame_type", t, ftype);
        cmp("strip_flag", a[15], strip);
        cmp("strip_bytes", s, sbytes);
    endtask
    function automatic logic [4:0] kexp(input int k, input int v);
        if (k < 5) return k[4:0];
        if (k == 5) return 5'h05 + v[4:0];
        if (k == 15) return 5'h1F;
        return k[4:0] + 5'h01;
    endfunction

    initial begin
        rst_i = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        cmp("key_reset", 32'h0, key);
        bus(1'b1, 32'h00, 32'h0);
        for (int k = 0; k < 16; k++) begin
            apply(32'h0, 32'h80020000 | k);
            cmp("next_key", kexp(k, 0), key);
            cmp("finished", k == 15, done);
            cmp("dst_fields", {k == 8, k == 8}, {dmac, dip});
        end
        bus(1'b1, 32'h00, 32'h1);
        apply(32'h0, 32'h80020005);
        cmp("next_key_idx", kexp(5, 1), key);
        bus(1'b0, 32'h00, 32'h0);
        cmp("ctrl", 32'h1, rd);
        $display("test key_select done");
        pt(32'h0000080A, 32'h8002C8C0, 8'h26, 2'h2, 8'h26);
        pt(32'h00064000, 32'h8003F040, 8'h28, 2'h3, 8'h28);
        pt(32'h00064014, 32'h8003F040, 8'h3C, 2'h3, 8'h2A);
        pt(32'h00000104, 32'h80014170, 8'h10, 2'h2, 8'h00);
        pt(32'h00000108, 32'h80007800, 8'h08, 2'h1, 8'h00);
        pt(32'h00000306, 32'h80024007, 8'h06, 2'h2, 8'h00);
        pt(32'h00006102, 32'h80027000, 8'h2A, 2'h3, 8'h00);
        $display("test pointer_moves done");
        bus(1'b0, 32'h0C, 32'h0);
        cmp("result_ptr", 32'h2A, rd[17:10]);
        cmp("result_type", 32'h3, rd[7:6]);
        cmp("result_word", {6'h00, 8'h00, 8'h2A, 1'b0, 1'b0, 2'h3, 1'b0, 5'h00}, rd);
        bus(1'b0, 32'h10, 32'h0);
        cmp("status", 32'h00000201, rd);
        bus(1'b0, 32'h04, 32'h0);
        cmp("act_go_clear", 32'h00027000, rd);
        bus(1'b0, 32'h20, 32'h0);
        cmp("unmapped", 32'h0, rd);
        cmp("far_applies", n_apply, applies);
        cmp("far_bytes", 32'h2A, taken);
        $display("test readback done");
        results();
    end
endmodule // cnls_steer_tb

bind cnls_steer cnls_steer_sva u_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hsel_i(hsel_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .next_key_o(next_key_o), .lookups_finished_o(lookups_finished_o), .frame_ptr_o(frame_ptr_o),
    .dst_in_source_mac_key_field_o(dst_in_source_mac_key_field_o), .strip_to_pointer_o(strip_to_pointer_o),
    .strip_bytes_o(strip_bytes_o), .result_valid_o(result_valid_o));
